// File: design/lsop_consts.svh
// Constants for the low side output status port.
`ifndef LSOP_CONSTS_SVH
`define LSOP_CONSTS_SVH
`define LSOP_OUT_ADDR        8'h00
`define LSOP_OUT_RESET       8'h00
`define LSOP_CLK_HZ          20000000
`define LSOP_FLASH_HZ        2
`define LSOP_HALF_CYCLES     (`LSOP_CLK_HZ / (2 * `LSOP_FLASH_HZ))
`define LSOP_CNT_W           24
`define LSOP_INDEX_WHOLE     16'h6200
`define LSOP_INDEX_SLOT_BASE 16'h7000
`define LSOP_SUB_FIRST       8'h01
`define LSOP_SUB_LAST        8'h08
`endif

// File: design/lsop_pkg.sv
// Types for the low side output status port.
package lsop_pkg;
  typedef enum logic [1:0] {
    LSOP_LAMP_OK    = 2'b00,
    LSOP_LAMP_FAULT = 2'b01,
    LSOP_LAMP_NOBUS = 2'b10,
    LSOP_LAMP_NOPWR = 2'b11
  } lsop_lamp_t;
endpackage

// File: design/lsop_flash.sv
// Divider that makes the fault lamp flash toggle.
`include "lsop_consts.svh"
module lsop_flash
  import lsop_pkg::*;
#(
  parameter int HALF_CYCLES = `LSOP_HALF_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic run,
  output logic      flash
);
  if (HALF_CYCLES < 1 || HALF_CYCLES >= (1 << `LSOP_CNT_W)) begin : g_bad_half
    $error("HALF_CYCLES out of range");
  end

  logic [`LSOP_CNT_W-1:0] cnt_reg;

  // R12: divider gated by error.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      flash   <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_reg <= '0;
        flash   <= 1'b0;
      end else if (cnt_reg == `LSOP_CNT_W'(HALF_CYCLES - 1)) begin
        cnt_reg <= '0;
        flash   <= ~flash;
      end else begin
        cnt_reg <= cnt_reg + `LSOP_CNT_W'(1);
      end
    end
  end

  // R12: flash half period.
  flash_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    (run && clk_en && cnt_reg == `LSOP_CNT_W'(HALF_CYCLES - 1)) |=> $changed(flash))
    else $error("Flash did not toggle at end of half period.");
endmodule

// File: design/lsop_port.sv
// Eight channel low side output port with lamp logic.
// What this block does
// R01: With bus working and no fault, bus-ok lamp is on steady and fault lamp dark.
// R02: With bus working and a module fault, both lamps are on steady.
// R03: With bus failed and a module fault, bus-ok is off and fault lamp on steady.
// R04: With bus power faulty, both lamps are dark.
// R05: On a configuration error with bus power good the fault lamp flashes at 2 Hz.
// R06: In normal operation each channel lamp follows its output bit.
// R07: One output byte at relative address zero, bit n drives channel n.
// R08: The block provides no input bytes to the head station.
// R09: A CANopen head station reaches the whole byte through index 6200h.
// R10: Slot access uses index 7000h plus slot, subindex 01h to 08h for bits 0 to 7.
// R11: Outputs hold the last written byte and are zero after reset.
// R12: The flash rate comes from a clock divider and runs only on a configuration error.
`include "lsop_consts.svh"
module lsop_port
  import lsop_pkg::*;
#(
  parameter int CHANNELS    = 8,
  parameter int HALF_CYCLES = `LSOP_HALF_CYCLES
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  input  wire logic                wr_en,
  input  wire logic [7:0]          wr_addr,
  input  wire logic [7:0]          wr_data,
  input  wire logic                bit_wr_en,
  input  wire logic [7:0]          object_subindex,
  input  wire logic                bit_wr_data,
  input  wire logic                bus_ok,
  input  wire logic                bus_power_ok,
  input  wire logic                config_error,
  input  wire logic                overload,
  input  wire logic                short_circuit,
  input  wire logic                overheat,
  output logic [CHANNELS-1:0]      out_chan,
  output logic [CHANNELS-1:0]      chan_lamp,
  output logic                     run_lamp,
  output logic                     fault_lamp,
  output logic [7:0]               in_bytes
);
  if (CHANNELS != 8) begin : g_bad_channels
    $error("CHANNELS must be 8");
  end

  // ==========================================================
  // Reset release.
  logic rst_s1_reg;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // ==========================================================
  // Output byte.
  function automatic logic sub_valid(input logic [7:0] s);
    sub_valid = (s >= `LSOP_SUB_FIRST) && (s <= `LSOP_SUB_LAST);
  endfunction

  logic [CHANNELS-1:0] out_reg;
  logic [CHANNELS-1:0] out_next;
  logic [2:0]          bit_sel;

  always_comb begin
    bit_sel  = 3'(object_subindex - `LSOP_SUB_FIRST);
    out_next = out_reg;
    // R07: byte write at offset zero.
    if (wr_en && wr_addr == `LSOP_OUT_ADDR) begin
      out_next = wr_data;
    // R10: subindex selects one bit.
    end else if (bit_wr_en && sub_valid(object_subindex)) begin
      out_next[bit_sel] = bit_wr_data;
    end
  end

  // R11: hold value, clear at reset.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= `LSOP_OUT_RESET;
    end else if (clk_en) begin
      out_reg <= out_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_chan <= `LSOP_OUT_RESET;
    end else if (clk_en) begin
      out_chan <= out_next;
    end
  end

  // R08: no input data.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_bytes <= 8'h00;
    end else begin
      in_bytes <= 8'h00;
    end
  end

  // ==========================================================
  // Lamps.
  logic       flash;
  logic       mod_fault;
  lsop_lamp_t lamp_mode;

  assign mod_fault = overload | short_circuit | overheat;

  lsop_flash #(
    .HALF_CYCLES (HALF_CYCLES)
  ) lsop_flash_inst (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .run     (config_error && bus_power_ok),
    .flash   (flash)
  );

  always_comb begin
    if (!bus_power_ok) begin
      lamp_mode = LSOP_LAMP_NOPWR;
    end else if (!bus_ok) begin
      lamp_mode = LSOP_LAMP_NOBUS;
    end else if (mod_fault) begin
      lamp_mode = LSOP_LAMP_FAULT;
    end else begin
      lamp_mode = LSOP_LAMP_OK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_lamp   <= 1'b0;
      fault_lamp <= 1'b0;
    end else if (clk_en) begin
      unique case (lamp_mode)
        // R01: steady green.
        LSOP_LAMP_OK: begin
          run_lamp   <= 1'b1;
          fault_lamp <= 1'b0;
        end
        // R02: both lamps lit.
        LSOP_LAMP_FAULT: begin
          run_lamp   <= 1'b1;
          fault_lamp <= 1'b1;
        end
        // R03: bus lost, fault lamp follows module fault.
        LSOP_LAMP_NOBUS: begin
          run_lamp   <= 1'b0;
          fault_lamp <= mod_fault;
        end
        // R04: power fault dark.
        LSOP_LAMP_NOPWR: begin
          run_lamp   <= 1'b0;
          fault_lamp <= 1'b0;
        end
      endcase
      // R05: configuration error flashes.
      if (config_error && bus_power_ok) begin
        fault_lamp <= flash;
      end
    end
  end

  // R06: lamps mirror outputs.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_lamp <= '0;
    end else if (clk_en) begin
      chan_lamp <= bus_ok ? out_next : '0;
    end
  end

  // ==========================================================
  // Checks.
  logic chk_en_reg;

  // Checks start one cycle after reset so the first registered update has settled.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chk_en_reg <= 1'b0;
    end else begin
      chk_en_reg <= 1'b1;
    end
  end

  byte_write_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R07
    (clk_en && wr_en && wr_addr == `LSOP_OUT_ADDR) |=> out_chan == $past(wr_data))
    else $error("Output byte not taken.");
  output_hold_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R11
    (!wr_en && !bit_wr_en) |=> $stable(out_chan))
    else $error("Outputs changed without a write.");
  bit_write_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R10
    (clk_en && !wr_en && bit_wr_en && sub_valid(object_subindex))
    |=> out_chan[$past(bit_sel)] == $past(bit_wr_data))
    else $error("Single bit write lost.");
  lamp_ok_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R01
    (clk_en && bus_power_ok && bus_ok && !mod_fault && !config_error) |=> run_lamp && !fault_lamp)
    else $error("Normal lamp pattern wrong.");
  lamp_fault_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R02
    (clk_en && bus_power_ok && bus_ok && mod_fault && !config_error) |=> run_lamp && fault_lamp)
    else $error("Fault lamp pattern wrong.");
  lamp_nobus_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R03
    (clk_en && bus_power_ok && !bus_ok && mod_fault && !config_error) |=> !run_lamp && fault_lamp)
    else $error("Bus loss lamp pattern wrong.");
  lamp_nopwr_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R04
    (clk_en && !bus_power_ok) |=> !run_lamp && !fault_lamp)
    else $error("Power fault lamps not dark.");
  lamp_flash_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R05
    (clk_en && config_error && bus_power_ok) |=> fault_lamp == $past(flash))
    else $error("Fault lamp not following flash.");
  chan_lamp_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R06
    (bus_ok && clk_en) ##1 (bus_ok && clk_en && !wr_en && !bit_wr_en) |=> chan_lamp == out_chan)
    else $error("Channel lamp differs from output.");
  no_input_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R08
    in_bytes == 8'h00)
    else $error("Input byte not zero.");
  flash_stop_a: assert property (@(posedge clk_sys) disable iff (!chk_en_reg) // R12
    (clk_en && !config_error) |=> !flash)
    else $error("Flash runs without a configuration error.");

  byte_cov_c:  cover property (@(posedge clk_sys) clk_en && wr_en && wr_addr == `LSOP_OUT_ADDR);
  bit_cov_c:   cover property (@(posedge clk_sys) clk_en && bit_wr_en && sub_valid(object_subindex));
  fault_cov_c: cover property (@(posedge clk_sys) run_lamp && fault_lamp);
  flash_cov_c: cover property (@(posedge clk_sys) config_error && $rose(fault_lamp));
  nobus_cov_c: cover property (@(posedge clk_sys) !run_lamp && fault_lamp);
endmodule

// File: verif/lsop_head_model.sv
// Head station model that writes the output byte and single output bits.
`include "lsop_consts.svh"
module lsop_head_model (
  input  wire logic  clk_sys,
  output logic       wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic       bit_wr_en,
  output logic [7:0] object_subindex,
  output logic       bit_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en = 1'b0;
    bit_wr_en = 1'b0;
    wr_addr = 8'hFF;
    wr_data = 8'h00;
    object_subindex = 8'hFF;
    bit_wr_data = 1'b0;
  end
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    wr_addr = addr;
    wr_data = data;
    wr_en = 1'b1;
    @(posedge clk_sys);
    #1;
    wr_en = 1'b0;
    wr_addr = ~addr;
    wr_data = ~data;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic write_whole(input logic [15:0] index, input logic [7:0] data);
    write_byte((index == `LSOP_INDEX_WHOLE) ? `LSOP_OUT_ADDR : 8'hFF, data);
  endtask
  task automatic write_bit(input logic [7:0] sub, input logic val);
    object_subindex = sub;
    bit_wr_data = val;
    bit_wr_en = 1'b1;
    @(posedge clk_sys);
    #1;
    bit_wr_en = 1'b0;
    object_subindex = ~sub;
    bit_wr_data = ~val;
    @(posedge clk_sys);
    #1;
  endtask
endmodule

// File: verif/lsop_port_tb.sv
// Self-checking testbench for the low side output port.
module lsop_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HC = 4;
  logic clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  logic wr_en, bit_wr_en, bit_wr_data, run_lamp, fault_lamp, prev;
  logic [7:0] wr_addr, wr_data, object_subindex, out_chan, chan_lamp, in_bytes, exp;
  logic bus_ok = 1'b1, bus_power_ok = 1'b1, config_error = 1'b0;
  logic overload = 1'b0, short_circuit = 1'b0, overheat = 1'b0;
  logic [6:0] tbl [6] = '{7'h62, 7'h73, 7'h6B, 7'h67, 7'h51, 7'h30};
  int n_mismatch = 0, checks = 0, tog;
  always #25 clk_sys = ~clk_sys;
  lsop_head_model lsop_head_model_inst (.clk_sys(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .bit_wr_en(bit_wr_en), .object_subindex(object_subindex), .bit_wr_data(bit_wr_data));
  lsop_port #(.HALF_CYCLES(HC)) lsop_port_inst (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .bit_wr_en(bit_wr_en),
    .object_subindex(object_subindex), .bit_wr_data(bit_wr_data), .bus_ok(bus_ok),
    .bus_power_ok(bus_power_ok), .config_error(config_error), .overload(overload),
    .short_circuit(short_circuit), .overheat(overheat), .out_chan(out_chan), .chan_lamp(chan_lamp),
    .run_lamp(run_lamp), .fault_lamp(fault_lamp), .in_bytes(in_bytes));
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic final_report();
    $display("Counts: checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  // ==========================================
  // Main sequence.
  initial begin
    tick(5);
    rst_b = 1'b1;
    tick(3);
    check(out_chan, 8'h00);
    check(in_bytes, 8'h00);
    lsop_head_model_inst.write_whole(16'h6200, 8'hA5);
    check(out_chan, 8'hA5);
    check(chan_lamp, 8'hA5);
    lsop_head_model_inst.write_byte(8'h00, 8'h5A);
    check(out_chan, 8'h5A);
    lsop_head_model_inst.write_byte(8'h01, 8'hFF);
    lsop_head_model_inst.write_whole(16'h6201, 8'hFF);
    tick(3);
    check(out_chan, 8'h5A);
    clk_en = 1'b0;
    lsop_head_model_inst.write_byte(8'h00, 8'hFF);
    clk_en = 1'b1;
    check(out_chan, 8'h5A);
    lsop_head_model_inst.write_byte(8'h00, 8'h00);
    exp = 8'h00;
    for (int k = 1; k <= 8; k++) begin
      lsop_head_model_inst.write_bit(8'(k), 1'b1);
      exp[k-1] = 1'b1;
      check(out_chan, exp);
    end
    lsop_head_model_inst.write_bit(8'h00, 1'b0);
    lsop_head_model_inst.write_bit(8'h09, 1'b0);
    check(out_chan, 8'hFF);
    lsop_head_model_inst.write_bit(8'h03, 1'b0);
    check(out_chan, 8'hFB);
    check(in_bytes, 8'h00);
    foreach (tbl[i]) begin
      {bus_power_ok, bus_ok, overload, short_circuit, overheat} = tbl[i][6:2];
      tick(2);
      check({6'h00, run_lamp, fault_lamp}, {6'h00, tbl[i][1:0]});
      if (bus_power_ok) check(chan_lamp, bus_ok ? 8'hFB : 8'h00);
    end
    {bus_power_ok, bus_ok, overload, short_circuit, overheat} = 5'h18;
    config_error = 1'b1;
    tick(1);
    prev = fault_lamp;
    tog = 0;
    for (int c = 0; c < 10 * HC; c++) begin
      tick(1);
      if (fault_lamp !== prev) tog++;
      prev = fault_lamp;
    end
    check(8'(tog), 8'h0A);
    config_error = 1'b0;
    tick(2);
    tog = 0;
    for (int c = 0; c < 4 * HC; c++) begin
      tick(1);
      if (fault_lamp !== 1'b0) tog++;
    end
    check(8'(tog), 8'h00);
    rst_b = 1'b0;
    tick(2);
    check(out_chan, 8'h00);
    check(chan_lamp, 8'h00);
    rst_b = 1'b1;
    tick(3);
    check({7'h00, run_lamp}, 8'h01);
    lsop_head_model_inst.write_byte(8'h00, 8'h3C);
    check(out_chan, 8'h3C);
    final_report();
  end
endmodule
